// ### hw/gpa_port_regs.sv
// Port A and port nine data registers with pin drive and read-back
//
// Summary of operation
// - Bit 6 of port_nine_data is read-only and shows its pin; the other bits are R/W, reset 0.
// - port_a_direction at offset 0xAB has eight write-only bits that reset to 0.
// - Each direction bit picks its pin's mode: 0 input, 1 output.
// - port_a_pin_levels is read-only and every read returns the present pin levels.
// - port_a_output_latch at offset 0xAA is R/W on all eight bits and resets to 0.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module gpa_port_regs
    import gpa_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire gpa_bus_req_s i_bus_req,
    output logic [GPA_DATA_W-1:0] o_rd_data,
    input wire logic [7:0] i_port_a_pin,
    output logic [7:0] o_port_a_pin_out,
    output logic [7:0] o_port_a_pin_oe,
    input wire logic i_port_nine_bit_six_pin,
    output logic [7:0] o_port_nine_data
);

    typedef enum {
        GPA_SEL_NONE,
        GPA_SEL_LATCH,
        GPA_SEL_DIR_PIN,
        GPA_SEL_NINE
    } gpa_sel_e;

    logic [7:0] port_a_output_latch_ff;
    logic [7:0] port_a_direction_ff;
    logic [7:0] port_nine_data_ff;
    logic [7:0] rd_data_ff;
    logic [7:0] nxt_rd_data;
    gpa_sel_e sel;

    // Decode shared by write and read paths
    function automatic gpa_sel_e gpa_decode(input logic [GPA_ADDR_W-1:0] addr);
        gpa_sel_e s;
        s = GPA_SEL_NONE;
        if (addr == GPA_OFF_PORT_A_OUTPUT_LATCH) begin
            s = GPA_SEL_LATCH;
        end else if (addr == GPA_OFF_PORT_A_DIRECTION) begin
            s = GPA_SEL_DIR_PIN;
        end else if (addr == GPA_OFF_PORT_NINE_DATA) begin
            s = GPA_SEL_NINE;
        end
        return s;
    endfunction : gpa_decode

    assign sel = gpa_decode(i_bus_req.addr);

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            port_a_output_latch_ff <= GPA_RST_PORT_A_OUTPUT_LATCH;
        end else if (i_bus_req.wr && sel == GPA_SEL_LATCH) begin
            port_a_output_latch_ff <= i_bus_req.wdata;
        end
    end

    // Direction shares its offset with the pin-level view: writes land here, reads see pins
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            port_a_direction_ff <= GPA_RST_PORT_A_DIRECTION;
        end else if (i_bus_req.wr && sel == GPA_SEL_DIR_PIN) begin
            port_a_direction_ff <= i_bus_req.wdata;
        end
    end

    // Bit 6 is not stored; it is patched in from the pin on read
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            port_nine_data_ff <= GPA_RST_PORT_NINE_DATA;
        end else if (i_bus_req.wr && sel == GPA_SEL_NINE) begin
            port_nine_data_ff <= i_bus_req.wdata & ~GPA_NINE_RO_MASK;
        end
    end

    always_comb begin
        nxt_rd_data = GPA_RD_UNMAPPED;
        case (sel)
            GPA_SEL_LATCH: begin
                nxt_rd_data = port_a_output_latch_ff;
            end
            GPA_SEL_DIR_PIN: begin
                nxt_rd_data = i_port_a_pin;
            end
            GPA_SEL_NINE: begin
                nxt_rd_data = port_nine_data_ff;
                nxt_rd_data[GPA_NINE_PIN_BIT] = i_port_nine_bit_six_pin;
            end
            default: begin
                nxt_rd_data = GPA_RD_UNMAPPED;
            end
        endcase
    end

    // Read data holds only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            rd_data_ff <= GPA_RD_UNMAPPED;
        end else if (i_bus_req.rd) begin
            rd_data_ff <= nxt_rd_data;
        end else begin
            rd_data_ff <= GPA_RD_UNMAPPED;
        end
    end

    assign o_rd_data = rd_data_ff;
    assign o_port_a_pin_oe = port_a_direction_ff;
    assign o_port_a_pin_out = port_a_output_latch_ff;
    assign o_port_nine_data = port_nine_data_ff;

    default clocking gpa_cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence latch_write_s;
        i_bus_req.wr && i_bus_req.addr == GPA_OFF_PORT_A_OUTPUT_LATCH;
    endsequence

    sequence latch_read_s;
        i_bus_req.rd && i_bus_req.addr == GPA_OFF_PORT_A_OUTPUT_LATCH;
    endsequence

    latch_readback_a: assert property (
        latch_write_s ##1 (latch_read_s and !i_bus_req.wr)
        |=> o_rd_data == $past(i_bus_req.wdata, 2))
        else $error("Output latch read-back differs from last write");

    dir_write_a: assert property (
        i_bus_req.wr && i_bus_req.addr == GPA_OFF_PORT_A_DIRECTION
        |=> o_port_a_pin_oe == $past(i_bus_req.wdata))
        else $error("Direction write did not reach output enables");

    pin_read_a: assert property (
        i_bus_req.rd && i_bus_req.addr == GPA_OFF_PORT_A_PIN_LEVELS
        |=> o_rd_data == $past(i_port_a_pin))
        else $error("Pin-level read did not return pin levels");

    dir_hold_a: assert property (
        i_reset_n && !(i_bus_req.wr && i_bus_req.addr == GPA_OFF_PORT_A_DIRECTION)
        |=> $stable(o_port_a_pin_oe))
        else $error("Pin direction changed without a direction write");

    drive_value_a: assert property (
        latch_write_s |=> o_port_a_pin_out == $past(i_bus_req.wdata))
        else $error("Driven pin value does not follow the output latch");

    nine_pin_a: assert property (
        i_bus_req.rd && i_bus_req.addr == GPA_OFF_PORT_NINE_DATA
        |=> o_rd_data[GPA_NINE_PIN_BIT] == $past(i_port_nine_bit_six_pin)
            && (o_rd_data & ~GPA_NINE_RO_MASK) == o_port_nine_data)
        else $error("Port nine read-back wrong");

    nine_ro_a: assert property (
        o_port_nine_data[GPA_NINE_PIN_BIT] == 1'b0)
        else $error("Port nine bit six was stored");

    rd_idle_a: assert property (
        !i_bus_req.rd |=> o_rd_data == GPA_RD_UNMAPPED)
        else $error("Read data outside the read answer cycle");

    reset_state_a: assert property (
        @(posedge i_sys_clk) disable iff (1'b0)
        !i_reset_n |=> o_port_a_pin_oe == GPA_RST_PORT_A_DIRECTION
            && o_port_a_pin_out == GPA_RST_PORT_A_OUTPUT_LATCH
            && o_port_nine_data == GPA_RST_PORT_NINE_DATA)
        else $error("Registers not at reset values after reset");

    // Bus phases that the multi-step checks below are built from
    sequence dir_write_s;
        i_bus_req.wr && i_bus_req.addr == GPA_OFF_PORT_A_DIRECTION;
    endsequence

    sequence pin_read_s;
        i_bus_req.rd && i_bus_req.addr == GPA_OFF_PORT_A_PIN_LEVELS;
    endsequence

    sequence nine_write_s;
        i_bus_req.wr && i_bus_req.addr == GPA_OFF_PORT_NINE_DATA;
    endsequence

    sequence nine_read_s;
        i_bus_req.rd && i_bus_req.addr == GPA_OFF_PORT_NINE_DATA;
    endsequence

    // Offsets outside the map must answer with the idle value, never stale data
    sequence unmapped_read_s;
        i_bus_req.rd
        && i_bus_req.addr != GPA_OFF_PORT_A_OUTPUT_LATCH
        && i_bus_req.addr != GPA_OFF_PORT_A_DIRECTION
        && i_bus_req.addr != GPA_OFF_PORT_NINE_DATA;
    endsequence

    // Write-only: a read right behind a direction write shows pins, not the direction
    dir_hidden_a: assert property (
        dir_write_s ##1 pin_read_s
        |=> o_rd_data == $past(i_port_a_pin))
        else $error("Direction value leaked onto the read bus");

    latch_hold_a: assert property (
        i_reset_n && !(i_bus_req.wr && i_bus_req.addr == GPA_OFF_PORT_A_OUTPUT_LATCH)
        |=> $stable(o_port_a_pin_out))
        else $error("Output latch changed without a latch write");

    nine_write_a: assert property (
        nine_write_s
        |=> o_port_nine_data == ($past(i_bus_req.wdata) & ~GPA_NINE_RO_MASK))
        else $error("Port nine write did not store the writable bits");

    nine_hold_a: assert property (
        i_reset_n && !(i_bus_req.wr && i_bus_req.addr == GPA_OFF_PORT_NINE_DATA)
        |=> $stable(o_port_nine_data))
        else $error("Port nine data changed without a write");

    nine_readback_a: assert property (
        nine_write_s ##1 nine_read_s
        |=> (o_rd_data & ~GPA_NINE_RO_MASK)
            == ($past(i_bus_req.wdata, 2) & ~GPA_NINE_RO_MASK))
        else $error("Port nine read-back differs from last write");

    unmapped_read_a: assert property (
        unmapped_read_s |=> o_rd_data == GPA_RD_UNMAPPED)
        else $error("Unmapped read returned data");

endmodule : gpa_port_regs
`default_nettype wire

// ### shared/gpa_pkg.sv
// Package with register map, widths and bus carrier for the port block
`default_nettype none
package gpa_pkg;
    localparam int GPA_ADDR_W = 8;
    localparam int GPA_DATA_W = 8;
    localparam logic [7:0] GPA_OFF_PORT_A_OUTPUT_LATCH = 8'hAA;
    localparam logic [7:0] GPA_OFF_PORT_A_DIRECTION = 8'hAB;
    localparam logic [7:0] GPA_OFF_PORT_A_PIN_LEVELS = 8'hAB;
    localparam logic [7:0] GPA_OFF_PORT_NINE_DATA = 8'hC1;
    localparam logic [7:0] GPA_RST_PORT_A_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] GPA_RST_PORT_A_DIRECTION = 8'h00;
    localparam logic [7:0] GPA_RST_PORT_NINE_DATA = 8'h00;
    localparam logic [7:0] GPA_RD_UNMAPPED = 8'h00;
    localparam int GPA_NINE_PIN_BIT = 6;
    localparam logic [7:0] GPA_NINE_RO_MASK = 8'h40;
    localparam logic GPA_DIR_INPUT = 1'b0;
    localparam logic GPA_DIR_OUTPUT = 1'b1;

    typedef struct packed {
        logic [GPA_ADDR_W-1:0] addr;
        logic [GPA_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } gpa_bus_req_s;
endpackage : gpa_pkg
`default_nettype wire

// ### sim/gpa_board_model.sv
// Board side of port A: resolves each pin from device drive and board level
`timescale 1ns/1ps
`default_nettype none
module gpa_board_model (
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_ext,
    output logic [7:0] o_pin
);
    // Driven bits follow the device, released bits show the board level
    assign o_pin = (i_out & i_oe) | (i_ext & ~i_oe);
endmodule : gpa_board_model
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the port register block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import gpa_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} gpa_row_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic p96 = 1'b0;
    gpa_bus_req_s req = '0;
    logic [7:0] rdata, pout, poe, ndata, pins, d;
    logic [7:0] ext = 8'h00;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    gpa_row_s rows [3] = '{'{8'hAA, 8'hA5, 8'hA5}, '{8'hC1, 8'hFF, 8'hBF},
        '{8'hAA, 8'h5A, 8'h5A}};
    initial begin
        forever #10 clk = ~clk;
    end
    gpa_port_regs dut_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_bus_req(req),
        .o_rd_data(rdata), .i_port_a_pin(pins), .o_port_a_pin_out(pout),
        .o_port_a_pin_oe(poe), .i_port_nine_bit_six_pin(p96), .o_port_nine_data(ndata));
    gpa_board_model board_u (.i_out(pout), .i_oe(poe), .i_ext(ext), .o_pin(pins));
    task automatic results();
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= w;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask : wr
    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd
    // Write then read with no idle cycle between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] w, output logic [7:0] v);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= w;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask : wr_rd
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("pin_out", 8'h00, pout);
        chk("pin_oe", 8'h00, poe);
        chk("nine", 8'h00, ndata);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, d);
            chk("row", rows[i].e, d);
        end
        chk("nine_data", 8'hBF, ndata);
        @(posedge clk) ext <= 8'hC3;
        rd(GPA_OFF_PORT_A_PIN_LEVELS, d);
        chk("pins_in", 8'hC3, d);
        wr(GPA_OFF_PORT_A_DIRECTION, 8'h0F);
        chk("oe", 8'h0F, poe);
        chk("drive", 8'h5A, pout);
        rd(8'hAB, d);
        chk("pins_mix", 8'hCA, d);
        @(posedge clk) p96 <= 1'b1;
        rd(8'hC1, d);
        chk("nine_pin", 8'hFF, d);
        rd(8'h10, d);
        chk("unmapped", 8'h00, d);
        // Back-to-back strobes: the read lands right behind the write
        wr_rd(8'hAA, 8'h3C, d);
        chk("b2b_latch", 8'h3C, d);
        @(posedge clk);
        #1;
        chk("rd_idle", 8'h00, rdata);
        wr_rd(8'hC1, 8'h15, d);
        chk("b2b_nine", 8'h55, d);
        wr_rd(8'hAB, 8'hF0, d);
        chk("b2b_dir", 8'h33, d);
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        #1;
        chk("oe_rst", 8'h00, poe);
        chk("out_rst", 8'h00, pout);
        chk("nine_rst", 8'h00, ndata);
        rd(8'hAA, d);
        chk("latch_rst", 8'h00, d);
        results();
    end
endmodule : tb
`default_nettype wire
